//--- mgmt_ctrl_defines.vh
/*
  Constants for the low-speed management and control block of a pluggable
  optical module: two-wire slave address, memory map layout, flag positions
  and timing figures.
  Assumes it is included by its bare name from the design file.
*/
`ifndef MGMT_CTRL_DEFINES_VH
`define MGMT_CTRL_DEFINES_VH

// ----------------------------------------------------------------------------
// Two-wire slave address and memory map.
// ----------------------------------------------------------------------------
`define TW_DEV_ADDR 7'h50
`define MAP_STATUS_ADDR 8'h02
`define MAP_FLAGS_ADDR 8'h03
`define MAP_POWER_CTRL_ADDR 8'h1a
`define STATUS_NOT_READY_BIT 0
`define FLAGS_FAULT_BIT 0
`define FLAGS_RESET_DONE_BIT 1
`define POWER_HIGH_EN_BIT 0
`define STATUS_RESET 8'h01
`define POWER_CTRL_RESET 8'h00

// ----------------------------------------------------------------------------
// Timing figures at a 125 MHz clock.
// ----------------------------------------------------------------------------
`define CLOCK_PERIOD_NS 8
`define RESET_MIN_PULSE_NS 10000
`define INIT_TIME_NS 2000000

`endif

//--- mgmt_ctrl.v
/*
  Low-speed management and control logic of a pluggable optical module:
  two-wire memory map slave gated by module select, reset pulse qualifier,
  initialization sequencer, power-mode control, presence and alert outputs.
  Assumes all pin inputs are asynchronous and an external wrapper resolves the
  open-drain pins from the output enables; host pull-ups sit on the board.
*/
`include "mgmt_ctrl_defines.vh"

module mgmt_ctrl #(
  parameter RESET_MIN_CYCLES = (`RESET_MIN_PULSE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS,
  parameter INIT_CYCLES = `INIT_TIME_NS / `CLOCK_PERIOD_NS,
  parameter CNT_W = 20
) (
  input wire clock,
  input wire rst,
  input wire module_select_n,
  input wire module_reset_n,
  input wire init_control_select,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out_q,
  output reg sda_oe_q,
  input wire fault_event,
  output reg alert_n_out_q,
  output reg alert_n_oe_q,
  output reg module_present_n_out_q,
  output reg module_present_n_oe_q,
  output reg low_power_request_q,
  output reg not_ready_q
);

  // --------------------------------------------------------------------------
  // Input synchronisers.
  // --------------------------------------------------------------------------
  // Pull-up on init mode is not modelled here: an undriven pin reads high at the wrapper.
  reg [4:0] sync1_q; // First stage, read only by the second stage.
  reg [4:0] sync2_q; // Second stage, used by logic.
  reg scl_prev_q; // Previous synchronised clock level.
  reg sda_prev_q; // Previous synchronised data level.

  // Two flip-flops on every pin input.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_q <= 5'h1f;
      sync2_q <= 5'h1f;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      sync1_q <= {module_select_n, module_reset_n, init_control_select, scl_in, sda_in};
      sync2_q <= sync1_q;
      scl_prev_q <= sync2_q[1];
      sda_prev_q <= sync2_q[0];
    end
  end

  wire sel_n = sync2_q[4];
  wire rst_pin_n = sync2_q[3];
  wire init_sw = sync2_q[2]; // High means software controlled initialisation.
  wire scl = sync2_q[1];
  wire sda = sync2_q[0];
  wire scl_rise = scl & ~scl_prev_q;
  wire scl_fall = ~scl & scl_prev_q;
  wire start_cond = scl & sda_prev_q & ~sda;
  wire stop_cond = scl & ~sda_prev_q & sda;

  // --------------------------------------------------------------------------
  // Reset pulse qualifier and initialisation sequencer.
  // --------------------------------------------------------------------------
  localparam ST_INIT = 2'b00;
  localparam ST_READY = 2'b01;
  reg [1:0] st_q; // Sequencer state.
  reg [CNT_W-1:0] low_cnt_q; // Length of the present reset low pulse.
  reg [CNT_W-1:0] init_cnt_q; // Initialisation time counter.
  reg soft_reset; // One-cycle qualified reset.

  // A low pulse counts only once it reaches the minimum length.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      low_cnt_q <= {CNT_W{1'b0}};
    end else if (rst_pin_n) begin
      low_cnt_q <= {CNT_W{1'b0}};
    end else if (low_cnt_q != RESET_MIN_CYCLES[CNT_W-1:0]) begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end
  end

  // Fires once, when the pulse reaches its minimum length.
  always @* begin
    soft_reset = ~rst_pin_n && (low_cnt_q == RESET_MIN_CYCLES[CNT_W-1:0] - 1'b1);
  end

  // Power-up starts in the init state, so completion posts with no host pulse.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q <= ST_INIT;
      init_cnt_q <= {CNT_W{1'b0}};
    end else if (soft_reset || (!rst_pin_n && st_q == ST_INIT)) begin
      st_q <= ST_INIT;
      init_cnt_q <= {CNT_W{1'b0}};
    end else begin
      case (st_q)
        ST_INIT: begin
          if (init_cnt_q == INIT_CYCLES[CNT_W-1:0] - 1'b1) begin
            st_q <= ST_READY;
          end else begin
            init_cnt_q <= init_cnt_q + 1'b1;
          end
        end
        default: begin
          st_q <= ST_READY;
        end
      endcase
    end
  end

  wire init_done = (st_q == ST_INIT) && (init_cnt_q == INIT_CYCLES[CNT_W-1:0] - 1'b1) && rst_pin_n;
  wire in_reset = soft_reset || (st_q == ST_INIT);

  // --------------------------------------------------------------------------
  // Two-wire slave.
  // --------------------------------------------------------------------------
  localparam TW_IDLE = 3'b000;
  localparam TW_ADDR = 3'b001;
  localparam TW_ACK = 3'b010;
  localparam TW_WR = 3'b011;
  localparam TW_RD = 3'b100;
  localparam TW_RACK = 3'b101;
  reg [2:0] tw_q; // Slave state.
  reg [2:0] tw_ret_q; // State to go to after an acknowledge.
  reg [3:0] bit_q; // Bit counter within a byte.
  reg [7:0] shift_q; // Receive shift register.
  reg [7:0] tx_q; // Transmit shift register.
  reg [7:0] ptr_q; // Memory map pointer.
  reg ptr_set_q; // Pointer byte received in this write.
  reg data_byte_q; // Last byte taken was a data byte, not the pointer byte.
  reg [7:0] status_q; // Status byte holding not-ready.
  reg [7:0] flags_q; // Latched event flags, clear on read.
  reg [7:0] power_q; // Power control byte.

  // Reads a memory map byte.
  function [7:0] map_read;
    input [7:0] addr;
    begin
      if (addr == `MAP_STATUS_ADDR) begin
        map_read = status_q;
      end else if (addr == `MAP_FLAGS_ADDR) begin
        map_read = flags_q;
      end else if (addr == `MAP_POWER_CTRL_ADDR) begin
        map_read = power_q;
      end else begin
        map_read = 8'h00;
      end
    end
  endfunction

  // A write commits only at the acknowledge of a data byte; the pointer byte neither stores nor advances.
  wire tw_write = (tw_q == TW_ACK) && scl_fall && (tw_ret_q == TW_WR) && data_byte_q && sda_oe_q;
  // The flags byte counts as read when its first bit is shifted out.
  wire flags_read = (tw_q == TW_ACK) && scl_fall && (tw_ret_q == TW_RD) && (ptr_q == `MAP_FLAGS_ADDR);

  // Byte engine, abandoned whenever select goes high.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      tw_q <= TW_IDLE;
      tw_ret_q <= TW_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      ptr_set_q <= 1'b0;
      data_byte_q <= 1'b0;
      sda_out_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (sel_n || stop_cond) begin
      tw_q <= TW_IDLE;
      sda_oe_q <= 1'b0;
    end else if (start_cond) begin
      tw_q <= TW_ADDR;
      bit_q <= 4'h0;
      ptr_set_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      case (tw_q)
        TW_ADDR, TW_WR: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda};
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            bit_q <= 4'h0;
            tw_q <= TW_ACK;
            if (tw_q == TW_ADDR) begin
              sda_oe_q <= (shift_q[7:1] == `TW_DEV_ADDR);
              tw_ret_q <= (shift_q[7:1] != `TW_DEV_ADDR) ? TW_IDLE : (shift_q[0] ? TW_RD : TW_WR);
              tx_q <= map_read(ptr_q);
              data_byte_q <= 1'b0;
            end else begin
              sda_oe_q <= 1'b1;
              tw_ret_q <= TW_WR;
              data_byte_q <= ptr_set_q;
              if (!ptr_set_q) begin
                ptr_q <= shift_q;
                ptr_set_q <= 1'b1;
              end
            end
          end
        end
        TW_ACK: begin
          if (scl_fall) begin
            tw_q <= tw_ret_q;
            if (tw_ret_q == TW_RD) begin
              sda_oe_q <= ~tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
              bit_q <= 4'h1;
            end else begin
              sda_oe_q <= 1'b0;
            end
            if (tw_write) begin
              ptr_q <= ptr_q + 8'h01;
            end
          end
        end
        TW_RD: begin
          if (scl_fall) begin
            if (bit_q == 4'h8) begin
              sda_oe_q <= 1'b0;
              bit_q <= 4'h0;
              tw_q <= TW_RACK;
              ptr_q <= ptr_q + 8'h01;
            end else begin
              sda_oe_q <= ~tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        TW_RACK: begin
          if (scl_rise) begin
            tw_q <= sda ? TW_IDLE : TW_ACK;
            tw_ret_q <= TW_RD;
            tx_q <= map_read(ptr_q);
          end
        end
        default: begin
          sda_oe_q <= 1'b0;
        end
      endcase
      sda_out_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Memory map bytes, flags and power mode.
  // --------------------------------------------------------------------------
  // Hardware sets win over the clear caused by reading the flags byte.
  // Only the bits handed to the host are cleared, so a later event is never lost.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      status_q <= `STATUS_RESET;
      flags_q <= 8'h00;
      power_q <= `POWER_CTRL_RESET;
      not_ready_q <= 1'b1;
      low_power_request_q <= 1'b1;
    end else begin
      if (in_reset && !init_done) begin
        status_q <= `STATUS_RESET;
        power_q <= `POWER_CTRL_RESET;
        not_ready_q <= 1'b1;
      end else begin
        if (init_done) begin
          status_q[`STATUS_NOT_READY_BIT] <= 1'b0;
          not_ready_q <= 1'b0;
        end
        if (tw_write && ptr_q == `MAP_POWER_CTRL_ADDR) begin
          power_q <= shift_q;
        end
      end
      flags_q <= (flags_read ? (flags_q & ~tx_q) : flags_q)
        | ({7'h00, fault_event} << `FLAGS_FAULT_BIT)
        | ({7'h00, init_done} << `FLAGS_RESET_DONE_BIT);
      low_power_request_q <= in_reset || (init_sw && !power_q[`POWER_HIGH_EN_BIT]);
    end
  end

  // --------------------------------------------------------------------------
  // Open-drain outputs.
  // --------------------------------------------------------------------------
  // Alert pulls low while any flag is pending; presence always pulls low.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      alert_n_out_q <= 1'b0;
      alert_n_oe_q <= 1'b0;
      module_present_n_out_q <= 1'b0;
      module_present_n_oe_q <= 1'b1;
    end else begin
      alert_n_out_q <= 1'b0;
      alert_n_oe_q <= (flags_q != 8'h00);
      module_present_n_out_q <= 1'b0;
      module_present_n_oe_q <= 1'b1;
    end
  end

endmodule // mgmt_ctrl

//--- mgmt_ctrl_assertions.sv
/*
  Port checker for the management and control block.
  Assumes it is bound to every mgmt_ctrl instance and sees its ports only.
*/
module mgmt_ctrl_checker #(
  parameter RESET_MIN_CYCLES = 4
) (
  input wire clock,
  input wire rst,
  input wire module_select_n,
  input wire module_reset_n,
  input wire init_control_select,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out_q,
  input wire sda_oe_q,
  input wire fault_event,
  input wire alert_n_out_q,
  input wire alert_n_oe_q,
  input wire module_present_n_out_q,
  input wire module_present_n_oe_q,
  input wire low_power_request_q,
  input wire not_ready_q
);
  // -------------------------------------------------------------------------
  // Helper logic
  // -------------------------------------------------------------------------
  // Cycles the reset pin has stayed low in a row, saturating.
  reg [31:0] low_q;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      low_q <= 32'h00000000;
    end else if (module_reset_n) begin
      low_q <= 32'h00000000;
    end else if (low_q != 32'hffffffff) begin
      low_q <= low_q + 32'h00000001;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  present_tie_a: assert property (module_present_n_oe_q && !module_present_n_out_q)
    else $error("presence line not held low");
  alert_od_a: assert property (!alert_n_out_q)
    else $error("alert line driven high");
  select_quiet_a: assert property (module_select_n [*6] |-> !sda_oe_q)
    else $error("data line driven while deselected");
  done_alert_a: assert property ($fell(not_ready_q) |=> alert_n_oe_q)
    else $error("no alert at end of init");
  init_hold_a: assert property ($fell(rst) |-> not_ready_q [*8])
    else $error("not-ready dropped early");
  short_pulse_a: assert property ($rose(not_ready_q) |-> low_q >= RESET_MIN_CYCLES)
    else $error("reset taken from short pulse");
  long_pulse_a: assert property (low_q == RESET_MIN_CYCLES + 3 |-> ##[0:3] not_ready_q)
    else $error("long reset pulse ignored");
  sw_low_a: assert property (init_control_select && not_ready_q |-> low_power_request_q)
    else $error("left low power too early");
  hw_high_a: assert property ((!init_control_select && module_reset_n && !not_ready_q) [*3] |-> !low_power_request_q)
    else $error("stuck in low power");
  fault_alert_a: assert property (fault_event |-> ##[1:3] alert_n_oe_q)
    else $error("fault raised no alert");
  // Main scenarios reached.
  c_ready: cover property ($fell(not_ready_q));
  c_ack: cover property ($rose(sda_oe_q));
  c_fault: cover property (fault_event ##[1:3] alert_n_oe_q);
endmodule // mgmt_ctrl_checker

bind mgmt_ctrl mgmt_ctrl_checker #(.RESET_MIN_CYCLES(RESET_MIN_CYCLES)) u_mgmt_ctrl_checker (
  .clock(clock), .rst(rst), .module_select_n(module_select_n), .module_reset_n(module_reset_n),
  .init_control_select(init_control_select), .scl_in(scl_in), .sda_in(sda_in), .sda_out_q(sda_out_q),
  .sda_oe_q(sda_oe_q), .fault_event(fault_event), .alert_n_out_q(alert_n_out_q), .alert_n_oe_q(alert_n_oe_q),
  .module_present_n_out_q(module_present_n_out_q), .module_present_n_oe_q(module_present_n_oe_q),
  .low_power_request_q(low_power_request_q), .not_ready_q(not_ready_q));

//--- host_model.sv
/*
  Host board controller: two-wire master tasks and board pull-ups.
  Assumes the bench calls its tasks and that inputs move on falling edges.
*/
`include "mgmt_ctrl_defines.vh"
module host_model (
  input wire clock,
  input wire sda_oe_q,
  input wire alert_n_oe_q,
  input wire module_present_n_oe_q,
  output reg scl,
  output wire sda,
  output wire alert_n,
  output wire module_present_n
);
  timeunit 1ns;
  timeprecision 1ps;
  reg sda_low = 1'b0;
  // Pull-ups: a released line reads high.
  assign sda = !(sda_low || sda_oe_q);
  assign alert_n = !alert_n_oe_q;
  assign module_present_n = !module_present_n_oe_q;
  initial scl = 1'b1;
  // Half an SCL phase, ten clocks, well above the synchroniser delay.
  task half;
    repeat (10) @(negedge clock);
  endtask
  // Data moves only well after SCL has fallen, never near its edges.
  task bitw(input b);
    begin
      sda_low = !b;
      half;
      scl = 1'b1;
      half;
      scl = 1'b0;
      repeat (4) @(negedge clock);
    end
  endtask
  task bitr(output v);
    begin
      sda_low = 1'b0;
      half;
      scl = 1'b1;
      v = sda;
      half;
      scl = 1'b0;
      repeat (4) @(negedge clock);
    end
  endtask
  task start;
    begin
      sda_low = 1'b0;
      scl = 1'b1;
      half;
      sda_low = 1'b1;
      half;
      scl = 1'b0;
      repeat (4) @(negedge clock);
    end
  endtask
  task stop;
    begin
      sda_low = 1'b1;
      half;
      scl = 1'b1;
      half;
      sda_low = 1'b0;
      half;
    end
  endtask
  // Byte out, most significant bit first; nak high when nobody answered.
  task wbyte(input [7:0] b, output nak);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bitw(b[i]);
      end
      bitr(nak);
    end
  endtask
  task wr(input [7:0] p, input [7:0] v);
    reg n;
    begin
      start;
      wbyte({`TW_DEV_ADDR, 1'b0}, n);
      wbyte(p, n);
      wbyte(v, n);
      stop;
    end
  endtask
  // Single byte read from pointer p, ended with a master NACK.
  task rd(input [7:0] p, output [7:0] d, output nak);
    reg n;
    integer i;
    begin
      start;
      wbyte({`TW_DEV_ADDR, 1'b0}, nak);
      wbyte(p, n);
      stop;
      start;
      wbyte({`TW_DEV_ADDR, 1'b1}, n);
      for (i = 7; i >= 0; i = i - 1) begin
        bitr(d[i]);
      end
      bitw(1'b1);
      stop;
    end
  endtask
endmodule // host_model

//--- test_mgmt_ctrl.sv
/*
  Self-checking bench for mgmt_ctrl with a host model.
  Assumes the design header sits beside the design files.
*/
`include "mgmt_ctrl_defines.vh"
module test_mgmt_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg sel_n = 1'b0;
  reg mrst_n = 1'b1;
  reg init_sel = 1'b1;
  reg fault = 1'b0;
  wire scl, sda, sda_o, sda_oe, al_o, al_oe, pr_o, pr_oe, lp, nr, alert_n, present_n;
  integer n_fail = 0;
  integer n_tests = 0;
  integer cyc = 0;
  integer i;
  reg [7:0] d;
  reg nak;
  // Row: pointer, write flag, write data, expected read, expected low power.
  reg [25:0] rows [0:4];
  mgmt_ctrl #(.RESET_MIN_CYCLES(4), .INIT_CYCLES(20), .CNT_W(20)) u_mgmt_ctrl (
    .clock(clock), .rst(rst), .module_select_n(sel_n), .module_reset_n(mrst_n),
    .init_control_select(init_sel), .scl_in(scl), .sda_in(sda), .sda_out_q(sda_o), .sda_oe_q(sda_oe),
    .fault_event(fault), .alert_n_out_q(al_o), .alert_n_oe_q(al_oe), .module_present_n_out_q(pr_o),
    .module_present_n_oe_q(pr_oe), .low_power_request_q(lp), .not_ready_q(nr));
  host_model u_host_model (.clock(clock), .sda_oe_q(sda_oe), .alert_n_oe_q(al_oe),
    .module_present_n_oe_q(pr_oe), .scl(scl), .sda(sda), .alert_n(alert_n), .module_present_n(present_n));
  initial forever #4 clock = ~clock;
  // Cut a hang short well past the expected run length.
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      summarize;
    end
  end
  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Reset pin low for n cycles, then time for init to finish.
  task pulse(input integer n);
    begin
      mrst_n = 1'b0;
      repeat (n) @(negedge clock);
      mrst_n = 1'b1;
      repeat (40) @(negedge clock);
    end
  endtask
  initial begin
    rows[0] = {8'h02, 1'b0, 8'h00, 8'h00, 1'b1};
    rows[1] = {8'h03, 1'b0, 8'h00, 8'h02, 1'b1};
    rows[2] = {8'h03, 1'b0, 8'h00, 8'h00, 1'b1};
    rows[3] = {8'h1a, 1'b1, 8'h01, 8'h01, 1'b0};
    rows[4] = {8'h40, 1'b0, 8'h00, 8'h00, 1'b0};
    repeat (10) @(negedge clock);
    rst = 1'b0;
    repeat (40) @(negedge clock);
    check(nr, 8'h00);
    check(alert_n, 8'h00);
    check(present_n, 8'h00);
    check(pr_o, 8'h00);
    check(al_o, 8'h00);
    check(sda_o, 8'h00);
    for (i = 0; i < 5; i = i + 1) begin
      if (rows[i][17]) u_host_model.wr(rows[i][25:18], rows[i][16:9]);
      u_host_model.rd(rows[i][25:18], d, nak);
      check(d, rows[i][8:1]);
      check(lp, rows[i][0]);
      $display("row %0d done", i);
    end
    check(alert_n, 8'h01);
    sel_n = 1'b1;
    u_host_model.rd(8'h02, d, nak);
    check(nak, 8'h01);
    check(d, 8'hff);
    check(sda_oe, 8'h00);
    sel_n = 1'b0;
    $display("deselect done");
    fault = 1'b1;
    @(negedge clock);
    fault = 1'b0;
    repeat (4) @(negedge clock);
    check(alert_n, 8'h00);
    u_host_model.rd(8'h03, d, nak);
    check(d, 8'h01);
    check(alert_n, 8'h01);
    $display("fault done");
    pulse(3);
    check(nr, 8'h00);
    check(lp, 8'h00);
    pulse(8);
    check(nr, 8'h00);
    check(alert_n, 8'h00);
    check(lp, 8'h01);
    u_host_model.rd(8'h1a, d, nak);
    check(d, 8'h00);
    $display("reset pin done");
    rst = 1'b1;
    init_sel = 1'b0;
    repeat (3) @(negedge clock);
    rst = 1'b0;
    repeat (40) @(negedge clock);
    check(lp, 8'h00);
    $display("hardware init done");
    summarize;
  end
endmodule // test_mgmt_ctrl
